//--- esgd_pkg.sv
package esgd_pkg;

  // ********************************************************
  // Geometry
  // ********************************************************
  localparam int          WORD_W      = 16;
  localparam int          FETCH_WORDS = 8;
  localparam int          N_DATA      = 4;
  localparam int          N_ADDR      = 2;
  localparam int          DEXT_W      = 3;
  localparam int          AEXT_W      = 2;
  localparam logic [3:0]  MAX_BASIC   = 4'h6;

  // ********************************************************
  // Word classification fields
  // ********************************************************
  localparam int          CLS_HI      = 15;
  localparam int          CLS_LO      = 14;
  localparam logic [1:0]  CLS_CHAIN   = 2'h0;
  localparam logic [1:0]  CLS_LASTB   = 2'h1;
  localparam logic [1:0]  CLS_SECOND  = 2'h2;
  localparam logic [1:0]  CLS_MISC    = 2'h3;
  localparam int          MULTI_BIT   = 13;
  localparam int          LEN3_BIT    = 12;
  localparam int          UNIT_BIT    = 11;
  localparam int          TAG_LO      = 11;
  localparam logic [4:0]  TAG_PFX1    = 5'h1F;
  localparam logic [4:0]  TAG_PFX2    = 5'h1E;

  // ********************************************************
  // Prefix first and second word fields
  // ********************************************************
  localparam int          PCNT_LO     = 0;
  localparam int          PCOND_LO    = 3;
  localparam int          PLOOPA_BIT  = 6;
  localparam int          PLOOPB_BIT  = 7;
  localparam int          PAEXT_LO    = 12;

  // Condition codes carried by a prefix
  localparam logic [2:0]  COND_ALWAYS     = 3'h0;
  localparam logic [2:0]  COND_SET        = 3'h1;
  localparam logic [2:0]  COND_CLEAR      = 3'h2;
  localparam logic [2:0]  COND_SET_CLEAR  = 3'h3;
  localparam logic [2:0]  COND_SET_ALWAYS = 3'h4;
  localparam logic [2:0]  COND_CLR_ALWAYS = 3'h5;

  // ********************************************************
  // Register map (byte addresses) and fields
  // ********************************************************
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_COUNT  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam int          CTRL_EN     = 0;
  localparam int          ST_MALF     = 0;
  localparam int          ST_COLL     = 1;
  localparam int          ST_LEN_LO   = 4;
  localparam int          ST_PFX      = 8;
  localparam logic        CTRL_RESET  = 1'b0;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ  = 2'h3;

endpackage : esgd_pkg

//--- esgd_word_class.sv
`timescale 1ns/1ps
// ********************************************************
// Classify one 16-bit word as a would-be instruction start
// ********************************************************
module esgd_word_class
  import esgd_pkg::*;
(
  input  wire logic [15:0] word,
  output logic             chain,
  output logic             is_misc,
  output logic             is_pfx1,
  output logic             is_pfx2,
  output logic             to_addr,
  output logic [3:0]       ilen
);

  // Top two bits give the serial group class
  always_comb begin
    chain   = (word[CLS_HI:CLS_LO] == CLS_CHAIN);
    is_misc = (word[CLS_HI:CLS_LO] == CLS_MISC);
    is_pfx1 = (word[CLS_HI:TAG_LO] == TAG_PFX1);
    is_pfx2 = (word[CLS_HI:TAG_LO] == TAG_PFX2);
    to_addr = word[UNIT_BIT];
    ilen    = 4'h1;
    // Multiword and two-word misc carry trailing extension words
    if (word[CLS_HI:CLS_LO] == CLS_SECOND && word[MULTI_BIT]) begin
      ilen = word[LEN3_BIT] ? 4'h3 : 4'h2;
    end else if (is_misc && word[LEN3_BIT]) begin
      ilen = 4'h2;
    end
  end

endmodule : esgd_word_class

//--- esgd_decoder.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Every instruction is a 16-bit word
// RULE_02 - Issue up to four data, two address
// RULE_03 - Grouping info selects instructions each cycle
// RULE_04 - Top bits 00 chain; others end set
// RULE_05 - Basic word 01 is last basic
// RULE_06 - Serial set size and mix limits
// RULE_07 - Secondary, multiword, misc end set; misc alone
// RULE_08 - Prefix gives all grouping info
// RULE_09 - Count field is words minus one
// RULE_10 - Count zero is undispatched no-op
// RULE_11 - Prefix words never reach units
// RULE_12 - Extract size, condition, loop marks, bank bits
// RULE_13 - Accept one or two prefix words
// RULE_14 - Operand fields select low eight registers
// RULE_15 - Second prefix word: four 3-bit, two 2-bit
// RULE_16 - Set bit selects high bank, else low
// RULE_17 - One-word prefix lacks bank bits only
// RULE_18 - Even positions subgroup one, odd two
// RULE_19 - Condition follows the T flag
// RULE_20 - No prefix falls back to serial grouping
module esgd_decoder
  import esgd_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite register slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic [31:0]                  hrdata,
  output logic                         hresp,
  // Fetch buffer window, word 0 is the oldest
  input  wire logic [7:0][15:0]        fetch_word,
  input  wire logic [3:0]              fetch_count,
  input  wire logic                    t_flag,
  output logic                         consume,
  output logic [3:0]                   consume_words,
  // Execution unit issue
  output logic                         set_issued,
  output logic [3:0]                   data_arith_unit_valid,
  output logic [3:0]                   data_arith_unit_enable,
  output logic [3:0][15:0]             data_arith_unit_word,
  output logic [3:0][2:0]              data_arith_unit_ext,
  output logic [1:0]                   agu_valid,
  output logic [1:0]                   agu_enable,
  output logic [1:0][15:0]             agu_word,
  output logic [1:0][1:0]              agu_ext,
  output logic                         loop_mark_first,
  output logic                         loop_mark_second
);

  // ********************************************************
  // Per-word classification
  // ********************************************************
  logic [7:0]       w_chain;
  logic [7:0]       w_misc;
  logic [7:0]       w_pfx1;
  logic [7:0]       w_pfx2;
  logic [7:0]       w_addr;
  logic [7:0][3:0]  w_len;

  // Every window slot is classified as if an instruction began there [RULE_01]
  for (genvar g = 0; g < FETCH_WORDS; g++) begin : g_cls
    esgd_word_class u_cls (
      .word    (fetch_word[g]),
      .chain   (w_chain[g]),
      .is_misc (w_misc[g]),
      .is_pfx1 (w_pfx1[g]),
      .is_pfx2 (w_pfx2[g]),
      .to_addr (w_addr[g]),
      .ilen    (w_len[g])
    );
  end

  // ********************************************************
  // Condition decode for a subgroup
  // ********************************************************
  function automatic logic cond_ok(input logic [2:0] code, input logic t, input logic odd);
    logic r;
    r = 1'b1;
    case (code)
      COND_SET:        r = t;                     // [RULE_19]
      COND_CLEAR:      r = !t;                    // [RULE_19]
      COND_SET_CLEAR:  r = odd ? !t : t;          // [RULE_18]
      COND_SET_ALWAYS: r = odd ? 1'b1 : t;        // [RULE_18]
      COND_CLR_ALWAYS: r = odd ? 1'b1 : !t;
      default:         r = 1'b1;
    endcase
    return r;
  endfunction : cond_ok

  // ********************************************************
  // Set boundary and routing
  // ********************************************************
  logic             ctrl_en;
  logic             consume_q;
  logic             pfx;
  logic             pfx2;
  logic [3:0]       start;
  logic [3:0]       total;
  logic [3:0]       nxt;
  logic [3:0]       slen;
  logic [3:0]       nbasic;
  logic             stop;
  logic             found;
  logic             malformed;
  logic             collide;
  logic [2:0]       cond;
  logic [3:0]       n_dv;
  logic [3:0]       n_de;
  logic [3:0][15:0] n_dw;
  logic [1:0]       n_av;
  logic [1:0]       n_ae;
  logic [1:0][15:0] n_aw;
  logic             fire;
  logic             drop;

  // Walk instruction starts of the current set [RULE_03]
  always_comb begin
    pfx2      = w_pfx2[0];
    pfx       = w_pfx1[0] || w_pfx2[0];                          // [RULE_08] [RULE_13]
    start     = pfx2 ? 4'h2 : (pfx ? 4'h1 : 4'h0);               // [RULE_11]
    total     = {1'b0, fetch_word[0][PCNT_LO +: 3]} + 4'h1;      // [RULE_09]
    cond      = pfx ? fetch_word[0][PCOND_LO +: 3] : COND_ALWAYS; // [RULE_17]
    nxt       = start;
    stop      = 1'b0;
    found     = pfx;
    slen      = pfx ? total : 4'h0;
    nbasic    = 4'h0;
    malformed = 1'b0;
    collide   = 1'b0;
    n_dv      = '0;
    n_de      = '0;
    n_dw      = '0;
    n_av      = '0;
    n_ae      = '0;
    n_aw      = '0;
    // A zero count is a no-op: one word, nothing dispatched [RULE_10]
    if (pfx && total == 4'h1) begin
      stop = 1'b1;
    end
    for (int i = 0; i < FETCH_WORDS; i++) begin
      if (!stop && nxt == 4'(i) && 4'(i) >= start) begin
        if (pfx && 4'(i) >= total) begin
          stop = 1'b1;
        end else begin
          // Data units by position mod 4, address units by parity [RULE_02]
          if (w_addr[i]) begin
            collide               = collide || n_av[i % 2];
            n_av[i % 2]           = 1'b1;
            n_aw[i % 2]           = fetch_word[i];
            n_ae[i % 2]           = cond_ok(cond, t_flag, i[0]);
          end else begin
            collide               = collide || n_dv[i % 4];
            n_dv[i % 4]           = 1'b1;
            n_dw[i % 4]           = fetch_word[i];
            n_de[i % 4]           = cond_ok(cond, t_flag, i[0]);
          end
          nxt = 4'(i) + w_len[i];
          if (!pfx) begin
            // Chained basic words continue; any other class ends the set [RULE_04] [RULE_05] [RULE_20]
            if (w_chain[i] || fetch_word[i][CLS_HI:CLS_LO] == CLS_LASTB) begin
              nbasic = nbasic + 4'h1;
            end
            if (!w_chain[i]) begin
              stop  = 1'b1;                                        // [RULE_07]
              found = 1'b1;
              slen  = nxt;
              // Misc may not follow a chained word [RULE_07]
              if (w_misc[i] && i > 0) begin
                malformed = 1'b1;
              end
            end
          end
        end
      end
    end
    // Too many basic words or a set past the fetch width is malformed [RULE_06]
    if (nbasic > MAX_BASIC || slen > 4'(FETCH_WORDS)) begin
      malformed = 1'b1;
    end
  end

  // A whole set must sit in the window; one idle cycle after each consume
  assign fire = ctrl_en && !consume_q && found && slen <= fetch_count && slen <= 4'(FETCH_WORDS);
  assign drop = ctrl_en && !consume_q && !found && fetch_count == 4'(FETCH_WORDS);

  // ********************************************************
  // Dispatch registers
  // ********************************************************
  // Valids are pulses; words hold their last value between sets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      consume       <= 1'b0;
      consume_words <= 4'h0;
      consume_q     <= 1'b0;
      set_issued    <= 1'b0;
      data_arith_unit_valid    <= '0;
      data_arith_unit_enable   <= '0;
      data_arith_unit_word     <= '0;
      agu_valid     <= '0;
      agu_enable    <= '0;
      agu_word      <= '0;
    end else begin
      consume       <= fire || drop;
      consume_words <= fire ? slen : (drop ? 4'(FETCH_WORDS) : 4'h0);
      consume_q     <= fire || drop;
      set_issued    <= fire;
      data_arith_unit_valid    <= fire ? n_dv : 4'h0;                       // [RULE_11]
      data_arith_unit_enable   <= fire ? n_de : 4'h0;
      agu_valid     <= fire ? n_av : 2'h0;
      agu_enable    <= fire ? n_ae : 2'h0;
      if (fire) begin
        data_arith_unit_word <= n_dw;
        agu_word  <= n_aw;
      end
    end
  end

  // Bank extension bits; low bank unless a two-word prefix sets them [RULE_15] [RULE_16]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_arith_unit_ext <= '0;
      agu_ext  <= '0;
    end else if (fire) begin
      for (int u = 0; u < N_DATA; u++) begin
        data_arith_unit_ext[u] <= pfx2 ? fetch_word[1][u*DEXT_W +: DEXT_W] : 3'h0;   // [RULE_14]
      end
      for (int v = 0; v < N_ADDR; v++) begin
        agu_ext[v] <= pfx2 ? fetch_word[1][PAEXT_LO + v*AEXT_W +: AEXT_W] : 2'h0;
      end
    end
  end

  // Loop marks come only from a prefix [RULE_12]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_mark_first  <= 1'b0;
      loop_mark_second <= 1'b0;
    end else begin
      loop_mark_first  <= fire && pfx && fetch_word[0][PLOOPA_BIT];
      loop_mark_second <= fire && pfx && fetch_word[0][PLOOPB_BIT];
    end
  end

  // ********************************************************
  // AHB-Lite slave
  // ********************************************************
  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_addr;
  logic        hit;
  logic [31:0] set_count;
  logic        st_malf;
  logic        st_coll;
  logic [3:0]  st_len;
  logic        st_pfx;
  logic        w1c_malf;
  logic        w1c_coll;

  assign hit      = hsel && hready && (htrans == HTRANS_NSEQ || htrans == HTRANS_SEQ);
  assign w1c_malf = ap_valid && ap_write && ap_addr == ADDR_STATUS && hwdata[ST_MALF];
  assign w1c_coll = ap_valid && ap_write && ap_addr == ADDR_STATUS && hwdata[ST_COLL];

  // Address phase capture; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_valid  <= hit;
      ap_write  <= hwrite;
      ap_addr   <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hit && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        ADDR_CTRL:   hrdata <= {31'h0, ctrl_en};
        ADDR_COUNT:  hrdata <= set_count;
        ADDR_STATUS: hrdata <= {23'h0, st_pfx, st_len, 2'b00, st_coll, st_malf};
        default:     hrdata <= 32'h0;
      endcase
    end
  end

  // Control: enable steers dispatch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en <= CTRL_RESET;
    end else if (ap_valid && ap_write && ap_addr == ADDR_CTRL) begin
      ctrl_en <= hwdata[CTRL_EN];
    end
  end

  // Status: sticky errors, hardware set beats software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_malf   <= 1'b0;
      st_coll   <= 1'b0;
      st_len    <= 4'h0;
      st_pfx    <= 1'b0;
      set_count <= 32'h0;
    end else begin
      st_malf <= ((fire && malformed) || drop) || (st_malf && !w1c_malf);
      st_coll <= (fire && collide) || (st_coll && !w1c_coll);
      if (fire) begin
        st_len    <= slen;
        st_pfx    <= pfx;
        set_count <= set_count + 32'h1;
      end
    end
  end

endmodule : esgd_decoder

//--- esgd_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Dispatch-side checks on the decoder ports
// ****************************************
module esgd_monitor
  import esgd_pkg::*;
(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic [7:0][15:0] fetch_word,
  input wire logic [3:0]       fetch_count,
  input wire logic             consume,
  input wire logic [3:0]       consume_words,
  input wire logic             set_issued,
  input wire logic [3:0]       data_arith_unit_valid,
  input wire logic [3:0]       data_arith_unit_enable,
  input wire logic [3:0][15:0] data_arith_unit_word,
  input wire logic [1:0]       agu_valid,
  input wire logic [1:0]       agu_enable,
  input wire logic [1:0][15:0] agu_word,
  input wire logic             loop_mark_first,
  input wire logic             loop_mark_second
);
  logic leak;
  // A slot holding a prefix tag means a prefix word escaped to a unit
  always_comb begin
    leak = 1'b0;
    for (int u = 0; u < 4; u++) leak = leak | (data_arith_unit_valid[u] && data_arith_unit_word[u][15:12] == 4'hF);
    for (int v = 0; v < 2; v++) leak = leak | (agu_valid[v] && agu_word[v][15:12] == 4'hF);
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Dispatch is a one-cycle pulse, then a quiet cycle
  sequence s_pulse;
    consume ##1 !consume;
  endsequence
  sequence s_issue;
    set_issued && consume;
  endsequence

  issue_gap_a: assert property (consume |-> s_pulse)
    else $error("dispatch pulse not followed by a gap");
  valid_issue_a: assert property ((|data_arith_unit_valid || |agu_valid) |-> s_issue)
    else $error("unit valid without an issued set");
  enable_valid_a: assert property (((data_arith_unit_enable & ~data_arith_unit_valid) == 4'h0) && ((agu_enable & ~agu_valid) == 2'h0))
    else $error("unit enabled without valid");
  loop_mark_a: assert property ((loop_mark_first || loop_mark_second) |-> s_issue)
    else $error("loop mark outside an issued set");
  whole_set_a: assert property (consume |-> consume_words != 4'h0 && consume_words <= $past(fetch_count))
    else $error("consumed more words than the window held");
  prefix_hidden_a: assert property (!leak)
    else $error("prefix word reached a unit");
  misc_alone_a: assert property (consume && $past(fetch_word[0][15:14]) == CLS_MISC && !$past(fetch_word[0][12])
    |-> consume_words == 4'h1)
    else $error("misc word grouped with others");
  last_basic_a: assert property (consume && $past(fetch_word[0][15:14]) == CLS_LASTB |-> consume_words == 4'h1)
    else $error("last basic word did not end the set");
  chain_two_a: assert property (consume && $past(fetch_word[0][15:14]) == CLS_CHAIN
    && $past(fetch_word[1][15:14]) == CLS_LASTB |-> consume_words == 4'h2)
    else $error("chained pair not dispatched as two words");
  pfx_count_a: assert property (consume && $past(fetch_word[0][15:11]) == TAG_PFX1
    |-> consume_words == {1'b0, $past(fetch_word[0][2:0])} + 4'h1 || $past(fetch_word[0][2:0]) == 3'h0)
    else $error("prefix count not honoured");
  noop_a: assert property (consume && $past(fetch_word[0][15:11]) == TAG_PFX1 && $past(fetch_word[0][2:0]) == 3'h0
    |-> s_issue and (consume_words == 4'h1 && data_arith_unit_valid == 4'h0 && agu_valid == 2'h0))
    else $error("empty prefix set was dispatched to a unit");
endmodule : esgd_monitor

bind esgd_decoder esgd_monitor u_mon (.*);

//--- esgd_fetch_model.sv
`timescale 1ns/1ps
// ****************************************
// Fetch buffer stand-in, one word in per cycle
// ****************************************
module esgd_fetch_model
  import esgd_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             push,
  input  wire logic [15:0]      push_word,
  input  wire logic             consume,
  input  wire logic [3:0]       consume_words,
  output logic      [7:0][15:0] fetch_word,
  output logic      [3:0]       fetch_count
);
  logic [15:0] buf_q[$];
  logic [15:0] churn;
  // Drop consumed words, append new one; empty slots churn so stale words never pass
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_q.delete();
      churn       <= 16'h5A3C;
      fetch_count <= 4'h0;
      fetch_word  <= '1;
    end else begin
      churn <= {churn[14:0], churn[15] ^ churn[13]};
      if (consume) begin
        for (int i = 0; i < consume_words && buf_q.size() > 0; i++) void'(buf_q.pop_front());
      end
      if (push) buf_q.push_back(push_word);
      fetch_count <= (buf_q.size() > 8) ? 4'h8 : 4'(buf_q.size());
      for (int i = 0; i < 8; i++) fetch_word[i] <= (i < buf_q.size()) ? buf_q[i] : churn ^ 16'(i);
    end
  end
endmodule : esgd_fetch_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import esgd_pkg::*;
  typedef struct packed {
    logic [3:0]       cw;
    logic             iss;
    logic [3:0]       dv, de;
    logic [3:0][15:0] dw;
    logic [3:0][2:0]  dx;
    logic [1:0]       av, ae;
    logic [1:0][15:0] aw;
    logic [1:0][1:0]  ax;
    logic             lm1, lm2;
  } esgd_exp_t;
  logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic             t_flag = 1'b0, push = 1'b0, hready, hreadyout, hresp;
  logic             consume, set_issued, loop_mark_first, loop_mark_second;
  logic [1:0]       htrans = 2'h0, agu_valid, agu_enable;
  logic [2:0]       hsize = 3'h2;
  logic [3:0]       consume_words, fetch_count, data_arith_unit_valid, data_arith_unit_enable;
  logic [15:0]      push_word = 16'h0;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h45, rd;
  logic [7:0][15:0] fetch_word;
  logic [3:0][15:0] data_arith_unit_word;
  logic [3:0][2:0]  data_arith_unit_ext;
  logic [1:0][15:0] agu_word;
  logic [1:0][1:0]  agu_ext;
  logic [15:0]      feed_q[$];
  esgd_exp_t        exp_q[$];
  int               bad_count = 0, checked = 0, cyc = 0, nsets = 0;

  assign hready = hreadyout;
  esgd_decoder u_dut (.*);
  esgd_fetch_model u_fb (.*);
  // ****************************************
  // Clock, feeder, observer, timeout
  // ****************************************
  always #10 hclk = ~hclk;
  // One word a cycle, so sets also sit half-fetched in the window
  always @(posedge hclk) begin
    push <= feed_q.size() > 0;
    if (feed_q.size() > 0) push_word <= feed_q.pop_front();
  end
  // Idle units are masked, their held words carry no meaning
  always @(posedge hclk) begin : observe
    esgd_exp_t o, e;
    if (hresetn && (consume || set_issued)) begin
      o = {consume_words, set_issued, data_arith_unit_valid, data_arith_unit_enable, data_arith_unit_word, data_arith_unit_ext,
           agu_valid, agu_enable, agu_word, agu_ext, loop_mark_first, loop_mark_second};
      for (int u = 0; u < 4; u++) if (!data_arith_unit_valid[u]) {o.dw[u], o.dx[u]} = '0;
      for (int v = 0; v < 2; v++) if (!agu_valid[v]) {o.aw[v], o.ax[v]} = '0;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      check("dispatch", o, e);
    end
  end
  // Roughly 4000 cycles of work; well past that means a hang
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic cond_on(input logic [2:0] c, input logic odd, input logic t);
    case (c)
      COND_SET:        return t;
      COND_CLEAR:      return !t;
      COND_SET_CLEAR:  return odd ? !t : t;
      COND_SET_ALWAYS: return odd | t;
      COND_CLR_ALWAYS: return odd | !t;
      default:         return 1'b1;
    endcase
  endfunction : cond_on
  // Later instruction on a shared unit overwrites the earlier one
  function automatic esgd_exp_t expect_set(input logic [15:0] ws[$], input logic [7:0] ins,
      input logic [2:0] c, input logic [15:0] ext, input logic [1:0] lm, input logic t);
    esgd_exp_t e;
    e = '0;
    e.cw = 4'(ws.size());
    e.iss = 1'b1;
    {e.lm2, e.lm1} = lm;
    for (int p = 0; p < ws.size(); p++) begin
      if (ins[p] && ws[p][UNIT_BIT]) begin
        e.av[p%2] = 1'b1;
        e.ae[p%2] = cond_on(c, p[0], t);
        e.aw[p%2] = ws[p];
        e.ax[p%2] = ext[12+2*(p%2) +: 2];
      end else if (ins[p]) begin
        e.dv[p%4] = 1'b1;
        e.de[p%4] = cond_on(c, p[0], t);
        e.dw[p%4] = ws[p];
        e.dx[p%4] = ext[3*(p%4) +: 3];
      end
    end
    return e;
  endfunction : expect_set
  task automatic check(input string what, input logic [130:0] seen, input logic [130:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // Single word transfer; waits on the slave's ready each phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    check("okay response", hresp, 1'b0);
  endtask : ahb
  task automatic send(input logic [15:0] ws[$], input esgd_exp_t e);
    foreach (ws[i]) feed_q.push_back(ws[i]);
    exp_q.push_back(e);
    nsets += e.iss;
  endtask : send
  task automatic drain();
    while (feed_q.size() > 0 || exp_q.size() > 0) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask : drain
  // Kinds: basic run, run plus secondary, run plus multiword, misc alone
  task automatic serial_set(input int kind);
    logic [15:0] ws[$];
    logic [7:0]  ins;
    logic [31:0] r;
    int          m;
    m = (kind == 0) ? 1 + rnd() % 6 : (kind == 3) ? 0 : rnd() % 6;
    for (int i = 0; i < m; i++) ws.push_back({2'b00, 14'(rnd())});
    ins = 8'hFF;
    r = rnd();
    if (kind == 0) ws[m-1][14] = 1'b1;
    if (kind == 1) ws.push_back({3'b100, r[12:0]});
    if (kind == 2) begin
      ws.push_back({3'b101, r[12:0]});
      ws.push_back(16'(rnd()));
      if (r[LEN3_BIT]) ws.push_back(16'(rnd()));
      ins = 8'((9'h1 << (m + 1)) - 1);
    end
    if (kind == 3) ws.push_back({4'hC, r[11:0]});
    send(ws, expect_set(ws, ins, COND_ALWAYS, 16'h0, 2'b00, 1'b0));
  endtask : serial_set
  task automatic prefix_set(input logic two, input logic [2:0] cnt);
    logic [15:0] ws[$];
    logic [31:0] r;
    logic [2:0]  c;
    r = rnd();
    c = 3'(r[10:8] % 6);
    if (cnt == 3'h0) r[7:6] = 2'b00;
    ws.push_back({two ? TAG_PFX2 : TAG_PFX1, r[2:0], r[7:6], c, cnt});
    if (two) ws.push_back(16'(rnd()));
    for (int i = ws.size(); i <= cnt; i++) ws.push_back({1'b0, r[14], 1'b0, 13'(rnd())});
    t_flag <= r[11];
    send(ws, expect_set(ws, two ? 8'hFC : 8'hFE, c, two ? ws[1] : 16'h0, r[7:6], r[11]));
    drain();
  endtask : prefix_set
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", rd, 32'h0);
    serial_set(0);
    repeat (20) @(posedge hclk);
    check("held while off", exp_q.size(), 1);
    ahb(1'b1, ADDR_CTRL, 32'h1, rd);
    for (int i = 0; i < 120; i++) begin
      serial_set(i % 4);
      serial_set(rnd() % 4);
      drain();
      prefix_set(1'b0, 3'(1 + rnd() % 7));
      prefix_set(1'b1, 3'(2 + rnd() % 6));
    end
    prefix_set(1'b0, 3'h0);
    for (int i = 0; i < 8; i++) feed_q.push_back({2'b00, 14'(rnd())});
    exp_q.push_back(esgd_exp_t'{cw: 4'h8, default: '0});
    drain();
    ahb(1'b0, ADDR_STATUS, 32'h0, rd);
    check("malformed flag", rd[ST_MALF], 1'b1);
    ahb(1'b1, ADDR_STATUS, 32'h1, rd);
    ahb(1'b0, ADDR_STATUS, 32'h0, rd);
    check("malformed cleared", rd[ST_MALF], 1'b0);
    ahb(1'b1, ADDR_COUNT, 32'h0, rd);
    ahb(1'b0, ADDR_COUNT, 32'h0, rd);
    check("set count", rd, 32'(nsets));
    ahb(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    finish_test();
  end
endmodule : testbench
